//--- hw/asq_consts.svh
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ASQ_ADDR_CMD      8'h00
`define ASQ_ADDR_RESULT   8'h04
`define ASQ_ADDR_STATUS   8'h08
`define ASQ_ADDR_CONFIG   8'h0c

// ----------------------------------------------------------------------
// control byte selector bits
// ----------------------------------------------------------------------
`define ASQ_SEL_CONV_B    7
`define ASQ_SEL_SETUP_B   6
`define ASQ_SEL_AVG_B     5
`define ASQ_SEL_RST_B     4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASQ_CKSEL_HI      5
`define ASQ_CKSEL_LO      4
`define ASQ_AVG_EN_B      4
`define ASQ_AVG_CNT_HI    3
`define ASQ_AVG_CNT_LO    2
`define ASQ_RPT_HI        1
`define ASQ_RPT_LO        0
`define ASQ_RST_FIFO_B    3

// ----------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------
`define ASQ_CK_EXT_START  2'b00
`define ASQ_CK_EXT_ACQ    2'b01
`define ASQ_CK_WRITE      2'b10
`define ASQ_SCAN_UP       2'b00
`define ASQ_SCAN_DOWN     2'b01
`define ASQ_SCAN_REPEAT   2'b10
`define ASQ_SCAN_ONE      2'b11
`define ASQ_SETUP_RST     8'h20
`define ASQ_BYTE_RST      8'h00
`define ASQ_LEAD_ZERO     4'h0
`define ASQ_SUB_ZERO      2'b00
`define ASQ_AVG_MIN_LOG   3'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ASQ_CLK_PS        5000
`define ASQ_START_MIN_NS  40
`define ASQ_ACQ_MIN_NS    1400

`endif

//--- hw/asq_pkg.sv
package asq_pkg;

	typedef enum {ST_IDLE, ST_TEMP, ST_CONV} asq_state_t;

	typedef enum {K_NONE, K_CONV, K_SETUP, K_AVG, K_RESET} asq_kind_t;

	typedef struct packed {
		logic       sel;
		logic [3:0] ch;
		logic [1:0] scan;
		logic       temp;
	} asq_conv_t;

	typedef struct packed {
		logic [3:0]  lead;
		logic [11:0] body;
	} asq_word_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} asq_dphase_t;

endpackage : asq_pkg

//--- hw/asq_top.sv
`timescale 1ns/1ps
`include "asq_consts.svh"
module asq_top
	import asq_pkg::*;
#(
	parameter int NCH      = 16,
	parameter int DEPTH    = 16,
	parameter int CONV_CYC = 16,
	parameter int TEMP_CYC = 64
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// host pins
	input  wire logic        convert_start_n_i,
	input  wire logic        chip_select_n_i,
	output logic             end_of_conv_n_o,
	// analog front end
	input  wire logic [9:0]  sample_i,
	input  wire logic [11:0] temp_i,
	output logic      [3:0]  mux_channel_o,
	output logic             awake_o
);

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam logic [8:0] START_CYC = 9'((`ASQ_START_MIN_NS * 1000
		+ `ASQ_CLK_PS - 1) / `ASQ_CLK_PS);
	localparam logic [8:0] ACQ_CYC   = 9'((`ASQ_ACQ_MIN_NS * 1000
		+ `ASQ_CLK_PS - 1) / `ASQ_CLK_PS);
	localparam logic [11:0] CONV_T   = 12'(CONV_CYC - 1);
	localparam logic [11:0] TEMP_T   = 12'(TEMP_CYC - 1);
	localparam int          AW       = $clog2(DEPTH);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	asq_dphase_t      dphase_q;
	logic [7:0]       setup_q;
	logic [7:0]       avg_q;
	asq_conv_t        conv_q;
	logic             conv_wr_q;
	logic             st_meta_q, st_sync_q, st_prev_q;
	logic             cs_meta_q, cs_sync_q, cs_prev_q;
	logic [8:0]       low_cnt_q;
	asq_state_t       state_q;
	logic [11:0]      timer_q;
	logic [3:0]       cur_ch_q;
	logic [4:0]       res_left_q;
	logic [5:0]       conv_cnt_q;
	logic [14:0]      sum_q;
	logic [1:0]       scan_q;
	logic             armed_q;
	logic             temp_pend_q;
	logic             eoc_n_q;
	asq_word_t        mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q, rd_ptr_q;
	logic [AW:0]      fifo_cnt_q;

	logic             cmd_wr, soft_all, soft_fifo, pop;
	logic [7:0]       wr_byte;
	asq_kind_t        wr_kind;
	logic [1:0]       mode;
	logic             st_rise, st_fall, cs_fall, rise_ok, idle;
	logic             start_scan, start_step;
	logic             phase_end, conv_end, push_temp, push_conv;
	logic             last_avg, last_res, scan_done, push;
	logic [5:0]       avg_n;
	logic [2:0]       avg_log;
	logic [14:0]      sum_next;
	logic [16:0]      sum_wide;
	logic [11:0]      res12;
	asq_word_t        push_word;

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic asq_kind_t byte_kind(input logic [7:0] b);
		if (b[`ASQ_SEL_CONV_B])
			return K_CONV;
		else if (b[`ASQ_SEL_SETUP_B])
			return K_SETUP;
		else if (b[`ASQ_SEL_AVG_B])
			return K_AVG;
		else if (b[`ASQ_SEL_RST_B])
			return K_RESET;
		else
			return K_NONE;
	endfunction : byte_kind

	function automatic logic [3:0] first_ch(input asq_conv_t c);
		return (c.scan == `ASQ_SCAN_UP) ? 4'h0 : c.ch;
	endfunction : first_ch

	function automatic logic [4:0] total_res(input asq_conv_t c,
		input logic [1:0] rpt);
		logic [4:0] n;
		n = 5'h01;
		unique case (c.scan)
			`ASQ_SCAN_UP:     n = 5'({1'b0, c.ch}) + 5'h01;
			`ASQ_SCAN_DOWN:   n = 5'(NCH - int'(c.ch));
			`ASQ_SCAN_REPEAT: n = 5'({rpt, 2'b00}) + 5'h04;
			`ASQ_SCAN_ONE:    n = 5'h01;
		endcase
		return n;
	endfunction : total_res

	// ------------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------------
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dphase_q <= '0;
		end else if (hready_i) begin
			dphase_q.valid <= hsel_i & htrans_i[1];
			dphase_q.write <= hwrite_i;
			dphase_q.addr  <= haddr_i[7:0];
		end
	end

	assign cmd_wr  = dphase_q.valid & dphase_q.write
		& (dphase_q.addr == `ASQ_ADDR_CMD);
	assign wr_byte = hwdata_i[7:0];
	assign wr_kind = cmd_wr ? byte_kind(wr_byte) : K_NONE;
	assign pop     = dphase_q.valid & ~dphase_q.write
		& (dphase_q.addr == `ASQ_ADDR_RESULT) & (fifo_cnt_q != '0);

	// read data is muxed from flops; an empty fifo reads as zero
	always_comb begin
		hrdata_o = 32'h0;
		if (dphase_q.valid && !dphase_q.write) begin
			unique case (dphase_q.addr)
				`ASQ_ADDR_RESULT:
					if (fifo_cnt_q != '0)
						hrdata_o = 32'(mem_q[rd_ptr_q]);
				`ASQ_ADDR_STATUS:
					hrdata_o = 32'({mode, armed_q, ~idle, eoc_n_q,
						5'(fifo_cnt_q)});
				`ASQ_ADDR_CONFIG:
					hrdata_o = 32'({conv_q, avg_q, setup_q});
				default:
					hrdata_o = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	assign soft_all  = (wr_kind == K_RESET) & ~wr_byte[`ASQ_RST_FIFO_B];
	assign soft_fifo = (wr_kind == K_RESET) & wr_byte[`ASQ_RST_FIFO_B];
	assign mode      = setup_q[`ASQ_CKSEL_HI:`ASQ_CKSEL_LO];

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			setup_q   <= `ASQ_SETUP_RST;
			avg_q     <= `ASQ_BYTE_RST;
			conv_q    <= `ASQ_BYTE_RST;
			conv_wr_q <= 1'b0;
		end else if (soft_all) begin
			setup_q   <= `ASQ_SETUP_RST;
			avg_q     <= `ASQ_BYTE_RST;
			conv_q    <= `ASQ_BYTE_RST;
			conv_wr_q <= 1'b0;
		end else begin
			conv_wr_q <= (wr_kind == K_CONV);
			if (wr_kind == K_SETUP)
				setup_q <= wr_byte;
			if (wr_kind == K_AVG)
				avg_q <= wr_byte;
			if (wr_kind == K_CONV)
				conv_q <= wr_byte;
		end
	end

	// ------------------------------------------------------------------
	// pin synchronisers and start pulse width
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_meta_q <= 1'b1;
			st_sync_q <= 1'b1;
			st_prev_q <= 1'b1;
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			st_meta_q <= convert_start_n_i;
			st_sync_q <= st_meta_q;
			st_prev_q <= st_sync_q;
			cs_meta_q <= chip_select_n_i;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
		end
	end

	assign st_rise = st_sync_q & ~st_prev_q;
	assign st_fall = ~st_sync_q & st_prev_q;
	assign cs_fall = ~cs_sync_q & cs_prev_q;

	// counts low cycles, saturating at the longest width that matters
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			low_cnt_q <= '0;
		else if (st_sync_q)
			low_cnt_q <= '0;
		else if (low_cnt_q < ACQ_CYC)
			low_cnt_q <= low_cnt_q + 9'h001;
	end

	// a temperature step is internally timed, so the short width serves
	assign rise_ok = st_rise & (low_cnt_q >= ((mode == `ASQ_CK_EXT_ACQ
		&& !temp_pend_q) ? ACQ_CYC : START_CYC));

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	assign idle       = (state_q == ST_IDLE);
	assign start_scan = idle & (((mode == `ASQ_CK_WRITE) & conv_wr_q)
		| ((mode == `ASQ_CK_EXT_START) & rise_ok));
	assign start_step = idle & (mode == `ASQ_CK_EXT_ACQ) & armed_q
		& rise_ok & ~conv_wr_q;

	assign avg_log   = avg_q[`ASQ_AVG_EN_B] ? 3'({1'b0,
		avg_q[`ASQ_AVG_CNT_HI:`ASQ_AVG_CNT_LO]}) + `ASQ_AVG_MIN_LOG
		: 3'h0;
	assign avg_n     = 6'(7'h01 << avg_log);
	assign phase_end = (timer_q == 12'h000);
	assign conv_end  = (state_q == ST_CONV) & phase_end;
	assign push_temp = (state_q == ST_TEMP) & phase_end;
	assign last_avg  = ((conv_cnt_q + 6'h01) == avg_n);
	assign last_res  = (res_left_q == 5'h01);
	assign push_conv = conv_end & last_avg;
	assign sum_next  = sum_q + 15'(sample_i);
	assign sum_wide  = {sum_next, `ASQ_SUB_ZERO} >> avg_log;
	assign res12     = sum_wide[11:0];
	assign scan_done = (mode == `ASQ_CK_EXT_ACQ) ? (push_temp | conv_end)
		: (push_conv & last_res);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q     <= ST_IDLE;
			timer_q     <= '0;
			cur_ch_q    <= '0;
			res_left_q  <= '0;
			conv_cnt_q  <= '0;
			sum_q       <= '0;
			scan_q      <= '0;
			armed_q     <= 1'b0;
			temp_pend_q <= 1'b0;
		end else if (soft_all) begin
			state_q     <= ST_IDLE;
			timer_q     <= '0;
			armed_q     <= 1'b0;
			temp_pend_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if ((mode == `ASQ_CK_EXT_ACQ) && conv_wr_q) begin
						cur_ch_q    <= first_ch(conv_q);
						res_left_q  <= total_res(conv_q,
							avg_q[`ASQ_RPT_HI:`ASQ_RPT_LO]);
						scan_q      <= conv_q.scan;
						conv_cnt_q  <= '0;
						sum_q       <= '0;
						armed_q     <= 1'b1;
						temp_pend_q <= conv_q.temp;
					end else if (start_scan) begin
						cur_ch_q   <= first_ch(conv_q);
						res_left_q <= total_res(conv_q,
							avg_q[`ASQ_RPT_HI:`ASQ_RPT_LO]);
						scan_q     <= conv_q.scan;
						conv_cnt_q <= '0;
						sum_q      <= '0;
						state_q    <= conv_q.temp ? ST_TEMP : ST_CONV;
						timer_q    <= conv_q.temp ? TEMP_T : CONV_T;
					end else if (start_step) begin
						temp_pend_q <= 1'b0;
						state_q     <= temp_pend_q ? ST_TEMP : ST_CONV;
						timer_q     <= temp_pend_q ? TEMP_T : CONV_T;
					end
				end
				ST_TEMP: begin
					if (phase_end) begin
						state_q <= (mode == `ASQ_CK_EXT_ACQ) ? ST_IDLE
							: ST_CONV;
						timer_q <= CONV_T;
					end else begin
						timer_q <= timer_q - 12'h001;
					end
				end
				ST_CONV: begin
					if (phase_end) begin
						timer_q <= CONV_T;
						state_q <= (mode == `ASQ_CK_EXT_ACQ) ? ST_IDLE
							: ST_CONV;
						if (last_avg) begin
							sum_q      <= '0;
							conv_cnt_q <= '0;
							res_left_q <= res_left_q - 5'h01;
							if (scan_q == `ASQ_SCAN_UP
								|| scan_q == `ASQ_SCAN_DOWN)
								cur_ch_q <= cur_ch_q + 4'h1;
							if (last_res) begin
								state_q <= ST_IDLE;
								armed_q <= 1'b0;
							end
						end else begin
							sum_q      <= sum_next;
							conv_cnt_q <= conv_cnt_q + 6'h01;
						end
					end else begin
						timer_q <= timer_q - 12'h001;
					end
				end
			endcase
		end
	end

	assign mux_channel_o = cur_ch_q;
	assign awake_o       = ~idle;

	// ------------------------------------------------------------------
	// end of conversion flag
	// ------------------------------------------------------------------
	// completion beats a release in the same cycle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			eoc_n_q <= 1'b1;
		else if (soft_all)
			eoc_n_q <= 1'b1;
		else if (scan_done)
			eoc_n_q <= 1'b0;
		else if (cs_fall || (st_fall && mode != `ASQ_CK_WRITE))
			eoc_n_q <= 1'b1;
	end

	assign end_of_conv_n_o = eoc_n_q;

	// ------------------------------------------------------------------
	// result fifo
	// ------------------------------------------------------------------
	assign push      = push_temp | push_conv;
	assign push_word = push_temp ? {`ASQ_LEAD_ZERO, temp_i}
		: {`ASQ_LEAD_ZERO, res12};

	// a push into a full fifo is dropped; the host must drain in time
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			fifo_cnt_q <= '0;
		end else if (soft_all || soft_fifo) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			fifo_cnt_q <= '0;
		end else begin
			if (push && fifo_cnt_q != (AW+1)'(DEPTH))
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push && fifo_cnt_q != (AW+1)'(DEPTH) && !pop)
				fifo_cnt_q <= fifo_cnt_q + 1'b1;
			else if (pop && !(push && fifo_cnt_q != (AW+1)'(DEPTH)))
				fifo_cnt_q <= fifo_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push && fifo_cnt_q != (AW+1)'(DEPTH))
			mem_q[wr_ptr_q] <= push_word;
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_avg_decode: assert property (@(posedge clock_i) disable iff (!resetn_i)
		cmd_wr && wr_byte[7:5] == 3'b001 && !soft_all
		|=> avg_q == $past(wr_byte))
		else $error("averaging byte not stored");

	a_no_avg_push: assert property (@(posedge clock_i)
		disable iff (!resetn_i)
		conv_end && !avg_q[`ASQ_AVG_EN_B] |-> push_conv)
		else $error("single conversion did not push");

	a_avg_steps: assert property (@(posedge clock_i) disable iff (!resetn_i)
		push_conv |-> conv_cnt_q == avg_n - 6'h01)
		else $error("average pushed at wrong count");

	a_full_reset: assert property (@(posedge clock_i) disable iff (!resetn_i)
		soft_all |=> setup_q == `ASQ_SETUP_RST && avg_q == `ASQ_BYTE_RST
		&& fifo_cnt_q == '0 && idle)
		else $error("full reset incomplete");

	a_fifo_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
		soft_fifo |=> fifo_cnt_q == '0 && $stable(setup_q))
		else $error("fifo clear wrong");

	a_short_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
		idle && mode == `ASQ_CK_EXT_START && st_rise
		&& low_cnt_q < START_CYC |=> idle)
		else $error("short start pulse accepted");

	a_acq_width: assert property (@(posedge clock_i) disable iff (!resetn_i)
		idle && mode == `ASQ_CK_EXT_ACQ && armed_q && !temp_pend_q
		&& st_rise && low_cnt_q < ACQ_CYC |=> idle)
		else $error("short acquisition accepted");

	a_eoc_done: assert property (@(posedge clock_i) disable iff (!resetn_i)
		scan_done && !soft_all |=> !end_of_conv_n_o)
		else $error("end flag not driven low");

	a_eoc_hold10: assert property (@(posedge clock_i)
		disable iff (!resetn_i)
		!eoc_n_q && mode == `ASQ_CK_WRITE && !cs_fall && !soft_all
		|=> !end_of_conv_n_o)
		else $error("end flag released without select");

	a_temp_first: assert property (@(posedge clock_i)
		disable iff (!resetn_i)
		start_scan && conv_q.temp && !soft_all
		|=> state_q == ST_TEMP ##1 state_q == ST_TEMP)
		else $error("temperature not first");

	a_step_once: assert property (@(posedge clock_i) disable iff (!resetn_i)
		conv_end && mode == `ASQ_CK_EXT_ACQ && !soft_all
		|=> idle && !end_of_conv_n_o)
		else $error("single step did not stop");

	a_repeat_len: assert property (@(posedge clock_i)
		disable iff (!resetn_i)
		start_scan && conv_q.scan == `ASQ_SCAN_REPEAT && !soft_all
		|=> res_left_q == 5'({$past(avg_q[`ASQ_RPT_HI:`ASQ_RPT_LO]), 2'b00})
		+ 5'h04)
		else $error("repeat count wrong");

endmodule : asq_top

//--- verif/adc_scan_average_sequencer_tb.sv
`timescale 1ns/1ps
`include "asq_consts.svh"
module adc_scan_average_sequencer_tb;
	import asq_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock_i  = 1'b0;
	logic        resetn_i = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [31:0] hwdata   = 32'h0;
	logic [1:0]  htrans   = 2'b00;
	logic        hwrite   = 1'b0;
	logic        rd_dp    = 1'b0;
	logic [9:0]  sample   = 10'h0;
	logic [11:0] temp     = 12'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        end_n;
	logic        start_n;
	logic        select_n;
	logic        hresp;
	logic        awake;
	logic [3:0]  mux_ch;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          fail_count      = 0;
	int          samples_checked = 0;
	int          seed            = 32'h36d0;
	bit          ok;

	always #2.5 clock_i = ~clock_i;

	asq_top #(.CONV_CYC(2), .TEMP_CYC(4)) dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.convert_start_n_i(start_n), .chip_select_n_i(select_n),
		.end_of_conv_n_o(end_n), .sample_i(sample), .temp_i(temp),
		.mux_channel_o(mux_ch), .awake_o(awake));

	asq_host_model host (
		.clock_i(clock_i), .end_n_i(end_n),
		.start_n_o(start_n), .select_n_o(select_n));

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked,
			fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check

	// read data is judged at the data-phase edge, oldest note first
	always @(posedge clock_i) begin
		if (rd_dp) begin
			check(hrdata & msk_q.pop_front(), exp_q.pop_front());
		end
	end

	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge clock_i);
		while (hready !== 1'b1) begin
			i++;
			if (i > 50) begin
				fail_count++;
				final_report();
			end
			@(posedge clock_i);
		end
	endtask : wait_rdy

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] m);
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		if (!w) begin
			rd_dp <= 1'b1;
			exp_q.push_back(d & m);
			msk_q.push_back(m);
		end
		wait_rdy();
		rd_dp <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] b);
		bus(`ASQ_ADDR_CMD, 1'b1, {24'h0, b}, 32'h0);
	endtask : wr

	task automatic res(input logic [31:0] e);
		bus(`ASQ_ADDR_RESULT, 1'b0, e, 32'hffffffff);
	endtask : res

	// bit 7 is left out: it depends on a pending mode 01 plan
	task automatic st(input logic [1:0] md, input logic e,
		input logic [4:0] n);
		bus(`ASQ_ADDR_STATUS, 1'b0, {22'h0, md, 2'b00, e, n}, 32'h37f);
		// every status read here falls between scans: asleep, response okay
		check({30'h0, hresp, awake}, 32'h0);
	endtask : st

	task automatic wait_end(output int c);
		for (c = 0; c < 5000 && end_n !== 1'b0; c++) begin
			@(posedge clock_i);
		end
		if (end_n !== 1'b0) begin
			fail_count++;
			final_report();
		end
	endtask : wait_end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		int n;
		int c;
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		st(2'b10, 1'b1, 5'd0);
		sample <= 10'($random(seed));
		temp   <= 12'($random(seed));
		wr(8'h20);
		wr(8'h9f);
		wait_end(c);
		res({20'h0, temp});
		res({20'h0, sample, 2'b00});
		st(2'b10, 1'b0, 5'd0);
		host.select();
		repeat (6) @(posedge clock_i);
		st(2'b10, 1'b1, 5'd0);
		// channels 0 to 1 upward, then 14 to 15: two results each
		wr(8'h88);
		wait_end(c);
		st(2'b10, 1'b0, 5'd2);
		host.select();
		wr(8'hf2);
		wait_end(c);
		st(2'b10, 1'b0, 5'd4);
		wr(8'h1f);
		host.select();
		for (n = 0; n < 4; n++) begin
			wr({6'b001011, n[1:0]});
			wr(8'h9c);
			wait_end(c);
			check(32'(mux_ch), 32'h3);
			st(2'b10, 1'b0, 5'(4 * (n + 1)));
			res({20'h0, sample, 2'b00});
			wr(8'h1f);
			st(2'b10, 1'b0, 5'd0);
			host.select();
		end
		for (n = 0; n < 4; n++) begin
			sample <= 10'($random(seed));
			wr({4'b0011, n[1:0], 2'b00});
			bus(`ASQ_ADDR_CONFIG, 1'b0, {16'h0, 4'h3, n[1:0], 10'h0},
				32'hff00);
			wr(8'h9e);
			wait_end(c);
			check(32'(c >= (4 << n) * 2), 32'h1);
			res({20'h0, sample, 2'b00});
			host.select();
		end
		wr(8'h40);
		st(2'b00, 1'b1, 5'd0);
		wr(8'h10);
		st(2'b10, 1'b1, 5'd0);
		bus(`ASQ_ADDR_CONFIG, 1'b0, {24'h0, `ASQ_SETUP_RST},
			32'hffffff);
		// mode 00: the conversion write alone must start nothing
		wr(8'h40);
		wr(8'h9e);
		st(2'b00, 1'b1, 5'd0);
		sample <= 10'($random(seed));
		host.strobe(10, ok);
		check(32'(ok), 32'h1);
		res({20'h0, sample, 2'b00});
		host.strobe(3, ok);
		check(32'(ok), 32'h0);
		st(2'b00, 1'b1, 5'd0);
		// mode 01: temperature on the first rise, then the channel
		wr(8'h50);
		wr(8'h9f);
		temp <= 12'($random(seed));
		host.strobe(10, ok);
		check(32'(ok), 32'h1);
		res({20'h0, temp});
		host.strobe(300, ok);
		check(32'(ok), 32'h1);
		res({20'h0, sample, 2'b00});
		st(2'b01, 1'b0, 5'd0);
		// mode 01 averaging: four pulses build one result
		wr(8'h30);
		wr(8'h9e);
		for (n = 0; n < 4; n++) begin
			host.strobe(300, ok);
			check(32'(ok), 32'h1);
			st(2'b01, 1'b0, 5'(n == 3));
		end
		res({20'h0, sample, 2'b00});
		final_report();
	end
endmodule : adc_scan_average_sequencer_tb

//--- verif/asq_host_model.sv
`timescale 1ns/1ps
module asq_host_model #(
	parameter int WAKE_CYC = 0
) (
	// clock and device pins
	input  wire logic clock_i,
	input  wire logic end_n_i,
	output logic      start_n_o,
	output logic      select_n_o
);
	// ----------------------------------------------------------------
	// strobe and select
	// ----------------------------------------------------------------
	initial begin
		start_n_o  = 1'b1;
		select_n_o = 1'b1;
	end

	// extra hold for reference wake-up; the device does not time it
	task automatic strobe(input int low, output bit ok);
		@(posedge clock_i);
		start_n_o <= 1'b0;
		repeat (low + WAKE_CYC) @(posedge clock_i);
		start_n_o <= 1'b1;
		ok = 1'b0;
		// no new strobe is allowed until the end flag falls
		for (int i = 0; i < 4000 && !ok; i++) begin
			@(posedge clock_i);
			ok = (end_n_i === 1'b0);
		end
	endtask : strobe

	task automatic select();
		@(posedge clock_i);
		if (end_n_i === 1'b0) begin
			select_n_o <= 1'b0;
		end
		repeat (4) @(posedge clock_i);
		select_n_o <= 1'b1;
	endtask : select
endmodule : asq_host_model
